// >>> logic/fsc_pkg.sv
// package: shared constants and types for the flash/sram bus controller
package fsc_pkg;
  localparam int ADDR_W = 21;
  localparam int RAM_ADDR_W = 17;
  localparam int DATA_W = 16;
  localparam int CLK_MHZ = 25;
  localparam int ACCESS_NS = 120;
  localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_NS = 200;
  localparam int RESET_CYC = (RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int TURN_CYC = 1;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

  typedef enum logic [1:0] {
    OP_RAM_READ = 2'h0,
    OP_RAM_WRITE = 2'h1,
    OP_NVM_READ = 2'h2,
    OP_NVM_WRITE = 2'h3
  } fsc_op_type;

  typedef struct packed {
    fsc_op_type op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] lanes_n;
  } fsc_req_type;

  typedef struct packed {
    logic nvm_ce_n;
    logic nvm_oe_n;
    logic nvm_we_n;
    logic ram_select_low_n;
    logic ram_select_high;
    logic ram_oe_n;
    logic ram_we_n;
    logic ram_low_lane_sel_n;
    logic ram_high_lane_sel_n;
  } fsc_strobe_type;

  localparam fsc_strobe_type STROBE_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage

// >>> logic/fsc_wait_timer.sv
// module: down counter for strobe phase lengths
`timescale 1ns/1ps
module fsc_wait_timer #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  output logic done
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  assign cnt_d = load ? count : ((cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
  assign done = (cnt_q == '0) && !load;
  always_ff @(posedge clock)
  begin
    if (rst)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
endmodule

// >>> logic/fsc_ctrl.sv
// module: host controller driving the combined flash/sram pins
`timescale 1ns/1ps
module fsc_ctrl #(
  parameter int ACCESS_CYCLES = fsc_pkg::ACCESS_CYC,
  parameter int RESET_CYCLES = fsc_pkg::RESET_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input wire fsc_pkg::fsc_req_type req,
  output logic req_ready,
  output logic resp_valid,
  output logic [fsc_pkg::DATA_W-1:0] resp_data,
  input wire logic nvm_reset_req,
  input wire logic protect_req,
  input wire logic lockdown_req,
  output logic [fsc_pkg::ADDR_W-1:0] addr,
  output fsc_pkg::fsc_strobe_type strobes,
  output logic nvm_reset_n,
  output logic nvm_wp_n,
  output logic nvm_vpp,
  input wire logic [fsc_pkg::DATA_W-1:0] dq_in,
  output logic [fsc_pkg::DATA_W-1:0] dq_out,
  output logic [fsc_pkg::DATA_W-1:0] dq_oe_n
);
  typedef enum logic [5:0] {
    ST_RESET = 6'h01,
    ST_IDLE = 6'h02,
    ST_SETUP = 6'h04,
    ST_STROBE = 6'h08,
    ST_RELEASE = 6'h10,
    ST_TURN = 6'h20
  } fsc_state_type;

  function automatic logic [fsc_pkg::DATA_W-1:0] lane_mask(input logic [1:0] lanes_n);
    lane_mask = {{8{~lanes_n[1]}}, {8{~lanes_n[0]}}};
  endfunction

  fsc_state_type state_q, state_d;
  fsc_pkg::fsc_req_type cur_q;
  fsc_pkg::fsc_strobe_type strobes_q, strobes_d;
  logic [fsc_pkg::ADDR_W-1:0] addr_q;
  logic [fsc_pkg::DATA_W-1:0] dq_out_q, dq_oe_n_q, resp_data_q;
  logic resp_valid_q, req_ready_q, nvm_reset_n_q, wp_n_q, vpp_q;
  logic timer_load, timer_done;
  logic [7:0] timer_count;
  logic is_write, is_nvm, take, finish;
  logic [fsc_pkg::DATA_W-1:0] read_mask;

  assign is_write = cur_q.op == fsc_pkg::OP_RAM_WRITE || cur_q.op == fsc_pkg::OP_NVM_WRITE;
  assign is_nvm = cur_q.op == fsc_pkg::OP_NVM_READ || cur_q.op == fsc_pkg::OP_NVM_WRITE;
  assign take = state_q == ST_IDLE && req_valid && !nvm_reset_req;
  assign finish = state_q == ST_STROBE && timer_done;
  // flash reads are full width; sram reads obey lane selects
  assign read_mask = is_nvm ? {fsc_pkg::DATA_W{1'b1}} : lane_mask(cur_q.lanes_n);

  // reset hold time is long enough to need a timer too
  assign timer_load = take || (state_q == ST_IDLE && nvm_reset_req) || state_q == ST_SETUP;
  assign timer_count = (state_q == ST_SETUP) ? 8'(ACCESS_CYCLES) : 8'(RESET_CYCLES);

  fsc_wait_timer #(.WIDTH(8)) u_timer (
    .clock(clock),
    .rst(rst),
    .load(timer_load),
    .count(timer_count),
    .done(timer_done)
  );

  always_comb
  begin
    state_d = state_q;
    strobes_d = strobes_q;
    case (state_q)
      ST_RESET:
      begin
        strobes_d = fsc_pkg::STROBE_IDLE;
        if (timer_done && !nvm_reset_req)
          state_d = ST_IDLE;
      end
      ST_IDLE:
      begin
        strobes_d = fsc_pkg::STROBE_IDLE;
        if (nvm_reset_req)
          state_d = ST_RESET;
        else if (req_valid)
          state_d = ST_SETUP;
      end
      ST_SETUP:
      begin
        // chip selects and lanes first, then the read or write strobe
        state_d = ST_STROBE;
        if (is_nvm)
          strobes_d.nvm_ce_n = 1'b0;
        else
        begin
          strobes_d.ram_select_low_n = 1'b0;
          strobes_d.ram_select_high = 1'b1;
          strobes_d.ram_low_lane_sel_n = cur_q.lanes_n[0];
          strobes_d.ram_high_lane_sel_n = cur_q.lanes_n[1];
        end
      end
      ST_STROBE:
      begin
        if (is_nvm && is_write)
          strobes_d.nvm_we_n = 1'b0;
        else if (is_nvm)
          strobes_d.nvm_oe_n = 1'b0;
        else if (is_write)
          strobes_d.ram_we_n = 1'b0;
        else
          strobes_d.ram_oe_n = 1'b0;
        if (timer_done)
        begin
          state_d = ST_RELEASE;
          // we rises before ce so data is taken on the we edge
          strobes_d.nvm_we_n = 1'b1;
          strobes_d.ram_we_n = 1'b1;
          strobes_d.nvm_oe_n = 1'b1;
          strobes_d.ram_oe_n = 1'b1;
        end
      end
      ST_RELEASE:
      begin
        strobes_d = fsc_pkg::STROBE_IDLE;
        state_d = ST_TURN;
      end
      ST_TURN:
        // one dead cycle keeps the two dies from fighting on dq
        state_d = ST_IDLE;
      default:
      begin
        state_d = ST_RESET;
        strobes_d = fsc_pkg::STROBE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= ST_RESET;
      strobes_q <= fsc_pkg::STROBE_IDLE;
    end
    else
    begin
      state_q <= state_d;
      strobes_q <= strobes_d;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cur_q <= '0;
      addr_q <= '0;
    end
    else if (take)
    begin
      cur_q <= req;
      // sram only sees the low 17 lines; the top bits are zeroed
      addr_q <= (req.op == fsc_pkg::OP_NVM_READ || req.op == fsc_pkg::OP_NVM_WRITE) ? req.addr
        : {{(fsc_pkg::ADDR_W-fsc_pkg::RAM_ADDR_W){1'b0}}, req.addr[fsc_pkg::RAM_ADDR_W-1:0]};
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      dq_out_q <= '0;
      dq_oe_n_q <= '1;
    end
    else if (state_q == ST_SETUP && is_write)
    begin
      dq_out_q <= cur_q.wdata;
      dq_oe_n_q <= is_nvm ? '0 : ~lane_mask(cur_q.lanes_n);
    end
    else if (state_q == ST_RELEASE || state_q == ST_IDLE || state_q == ST_RESET)
      dq_oe_n_q <= '1;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      resp_valid_q <= 1'b0;
      resp_data_q <= '0;
      req_ready_q <= 1'b0;
    end
    else
    begin
      resp_valid_q <= finish;
      if (finish && !is_write)
        resp_data_q <= dq_in & read_mask;
      req_ready_q <= state_d == ST_IDLE && !nvm_reset_req;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      nvm_reset_n_q <= 1'b0;
      wp_n_q <= 1'b0;
      vpp_q <= 1'b0;
    end
    else
    begin
      nvm_reset_n_q <= state_d != ST_RESET;
      wp_n_q <= !lockdown_req;
      vpp_q <= !protect_req;
    end
  end

  assign addr = addr_q;
  assign strobes = strobes_q;
  assign nvm_reset_n = nvm_reset_n_q;
  assign nvm_wp_n = wp_n_q;
  assign nvm_vpp = vpp_q;
  assign dq_out = dq_out_q;
  assign dq_oe_n = dq_oe_n_q;
  assign resp_valid = resp_valid_q;
  assign resp_data = resp_data_q;
  assign req_ready = req_ready_q;
endmodule

// >>> verification/fsc_ctrl_assertions.sv
// checker: pin rules of the flash/sram controller
`timescale 1ns/1ps
module fsc_ctrl_assertions (
  input wire logic clock,
  input wire logic rst,
  input wire logic protect_req,
  input wire logic [20:0] addr,
  input wire fsc_pkg::fsc_strobe_type strobes,
  input wire logic nvm_reset_n,
  input wire logic nvm_vpp,
  input wire logic [15:0] dq_oe_n
);
  fsc_pkg::fsc_strobe_type s;
  assign s = strobes;
  wire ram_on = !s.ram_select_low_n && s.ram_select_high;
  wire nvm_rd = !s.nvm_ce_n && !s.nvm_oe_n;
  wire [15:0] lane_n = {{8{s.ram_high_lane_sel_n}}, {8{s.ram_low_lane_sel_n}}};
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence we_release;
    $rose(s.nvm_we_n);
  endsequence
  one_driver_a: assert property (!(nvm_rd && ram_on && !s.ram_oe_n))
    else $error("two dies read");
  nvm_read_a: assert property (nvm_rd |-> s.nvm_we_n && nvm_reset_n && dq_oe_n == 16'hFFFF)
    else $error("bad flash read");
  nvm_write_a: assert property (!s.nvm_we_n |-> !s.nvm_ce_n && s.nvm_oe_n && nvm_reset_n && dq_oe_n == 16'h0000)
    else $error("bad flash write");
  we_first_a: assert property (we_release |-> !s.nvm_ce_n ##1 s.nvm_ce_n)
    else $error("bad write release");
  ram_write_a: assert property (!s.ram_we_n |-> ram_on && s.ram_oe_n && dq_oe_n == lane_n)
    else $error("bad ram write");
  ram_read_a: assert property (ram_on && !s.ram_oe_n |-> s.ram_we_n && dq_oe_n == 16'hFFFF)
    else $error("bad ram read");
  ram_addr_a: assert property (ram_on |-> addr[20:17] == 4'h0)
    else $error("ram address high");
  reset_quiet_a: assert property (!nvm_reset_n |-> s.nvm_ce_n && s.nvm_we_n)
    else $error("flash used in reset");
  protect_a: assert property (protect_req |=> !nvm_vpp)
    else $error("no protect");
endmodule

// >>> verification/fsc_mem_model.sv
// model: flash and sram dies on the shared bus
`timescale 1ns/1ps
module fsc_mem_model (
  input wire logic [20:0] addr,
  input wire fsc_pkg::fsc_strobe_type strobes,
  input wire logic nvm_reset_n,
  input wire logic nvm_vpp,
  input wire logic [15:0] dq_in,
  output logic [15:0] dev_dq,
  output logic [15:0] dev_oe_n
);
  logic [15:0] ram [0:131071];
  // kept inverted so an unwritten word reads as erased ffff
  bit [15:0] nvm_n [0:2097151];
  logic [7:0] cmd = 8'h00;
  // status mode kept per bank; the command latch is shared, a simplification
  logic [1:0] stat = 2'b00;
  // bottom boot: eight 4K plus seven 32K blocks below, fifty-six 32K blocks above
  wire bank = addr >= 21'h040000;
  wire nvm_on = nvm_reset_n && !strobes.nvm_ce_n;
  wire nvm_rd = nvm_on && !strobes.nvm_oe_n && strobes.nvm_we_n;
  wire ram_on = !strobes.ram_select_low_n && strobes.ram_select_high;
  wire ram_rd = ram_on && !strobes.ram_oe_n && strobes.ram_we_n;
  wire [15:0] ln = {{8{strobes.ram_high_lane_sel_n}}, {8{strobes.ram_low_lane_sel_n}}};
  assign dev_oe_n = nvm_rd ? 16'h0000 : ram_rd ? ln : 16'hFFFF;
  assign dev_dq = nvm_rd ? (stat[bank] ? 16'h0080 : ~nvm_n[addr]) : ram[addr[16:0]];
  always @(negedge nvm_reset_n)
  begin
    stat = 2'b00;
    cmd = 8'h00;
  end
  // capture on the we rise, ce is still low then
  always @(posedge strobes.nvm_we_n)
    if (nvm_on && strobes.nvm_oe_n)
    begin
      if (cmd == fsc_pkg::CMD_PROGRAM && nvm_vpp)
        nvm_n[addr] = ~dq_in;
      stat[bank] = cmd == fsc_pkg::CMD_PROGRAM || dq_in[7:0] == fsc_pkg::CMD_READ_STATUS;
      cmd = cmd == fsc_pkg::CMD_PROGRAM ? 8'h00 : dq_in[7:0];
    end
  always @(posedge strobes.ram_we_n)
    if (ram_on && strobes.ram_oe_n)
      ram[addr[16:0]] = ram[addr[16:0]] & ln | dq_in & ~ln;
endmodule

// >>> verification/flash_sram_shared_bus_decode_tb_top.sv
// testbench: controller against the memory model
`timescale 1ns/1ps
module flash_sram_shared_bus_decode_tb_top;
  logic clock, rst, req_valid, req_ready, resp_valid, nvm_reset_req, protect_req, lockdown_req;
  fsc_pkg::fsc_req_type req;
  fsc_pkg::fsc_strobe_type strobes;
  logic [15:0] resp_data, dq_in, dq_out, dq_oe_n, dev_dq, dev_oe_n, rd;
  logic [20:0] addr;
  logic nvm_reset_n, nvm_wp_n, nvm_vpp;
  logic tgl = 1'b0;
  int fail_count = 0;
  int checks_done = 0;
  int n;
  // a floating bit toggles so it never reads back as a stale value
  assign dq_in = ~dq_oe_n & dq_out | ~dev_oe_n & dev_dq | dq_oe_n & dev_oe_n & {16{tgl}};
  fsc_ctrl uut (.*);
  fsc_mem_model mem (.*);
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock)
    tgl <= ~tgl;
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input fsc_pkg::fsc_op_type op, input logic [20:0] a, input logic [15:0] d, input logic [1:0] l);
    req <= '{op, a, d, l};
    req_valid <= 1'b1;
    n = 0;
    do @(posedge clock); while (req_ready !== 1'b1 && ++n < 60);
    req_valid <= 1'b0;
    do @(posedge clock); while (resp_valid !== 1'b1 && ++n < 120);
    rd = resp_data;
    if (n >= 120)
    begin
      fail_count++;
      finish_test;
    end
  endtask
  task automatic nw(input logic [20:0] a, input logic [15:0] d);
    acc(fsc_pkg::OP_NVM_WRITE, a, d, 2'b00);
  endtask
  task automatic t_ram;
    acc(fsc_pkg::OP_RAM_WRITE, 21'h1FFFFF, 16'h1234, 2'b00);
    chk({15'h0000, nvm_wp_n}, 16'h0001);
    chk({15'h0000, nvm_vpp}, 16'h0001);
    acc(fsc_pkg::OP_RAM_WRITE, 21'h1FFFFF, 16'hABCD, 2'b10);
    acc(fsc_pkg::OP_RAM_READ, 21'h01FFFF, 16'h0000, 2'b00);
    chk(rd, 16'h12CD);
    acc(fsc_pkg::OP_RAM_READ, 21'h01FFFF, 16'h0000, 2'b01);
    chk(rd, 16'h1200);
    $display("ram test done");
  endtask
  task automatic t_nvm;
    nw(21'h1FFFFF, 16'h0040);
    nw(21'h1FFFFF, 16'h5A3C);
    acc(fsc_pkg::OP_RAM_READ, 21'h01FFFF, 16'h0000, 2'b00);
    chk(rd, 16'h12CD);
    acc(fsc_pkg::OP_NVM_READ, 21'h03FFFF, 16'h0000, 2'b00);
    chk(rd, 16'hFFFF);
    acc(fsc_pkg::OP_NVM_READ, 21'h1FFFFF, 16'h0000, 2'b00);
    chk(rd, 16'h0080);
    nw(21'h1FFFFF, 16'h00FF);
    acc(fsc_pkg::OP_NVM_READ, 21'h1FFFFF, 16'h0000, 2'b00);
    chk(rd, 16'h5A3C);
    $display("flash test done");
  endtask
  task automatic t_protect;
    protect_req <= 1'b1;
    lockdown_req <= 1'b1;
    nw(21'h000010, 16'h0040);
    nw(21'h000010, 16'h7777);
    nw(21'h000010, 16'h00FF);
    acc(fsc_pkg::OP_NVM_READ, 21'h000010, 16'h0000, 2'b00);
    chk(rd, 16'hFFFF);
    chk({15'h0000, nvm_wp_n}, 16'h0000);
    protect_req <= 1'b0;
    lockdown_req <= 1'b0;
    $display("protect test done");
  endtask
  task automatic t_reset;
    nw(21'h1FFFFF, 16'h0070);
    nvm_reset_req <= 1'b1;
    repeat (fsc_pkg::RESET_CYC + 2) @(posedge clock);
    chk({15'h0000, nvm_reset_n}, 16'h0000);
    nvm_reset_req <= 1'b0;
    acc(fsc_pkg::OP_NVM_READ, 21'h1FFFFF, 16'h0000, 2'b00);
    chk(rd, 16'h5A3C);
    $display("reset test done");
  endtask
  initial
  begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    nvm_reset_req = 1'b0;
    protect_req = 1'b0;
    lockdown_req = 1'b0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_ram;
    t_nvm;
    t_protect;
    t_reset;
    finish_test;
  end
endmodule
bind fsc_ctrl fsc_ctrl_assertions chk (.*);
